// File: verilog/ucd_regs.svh
// constants for the uart channel: addresses, counts and idle levels
`ifndef UCD_REGS_SVH
`define UCD_REGS_SVH

// host address of the data port outside a dma cycle
`define UCD_DATA_ADDR      3'h0
// last tick of a sixteen-tick bit
`define UCD_BIT_LAST       4'hF
// tick at which a start bit is checked
`define UCD_MID_SAMPLE     4'h7
// infrared pulse length in sixteenth ticks
`define UCD_IR_PULSE_TICKS 4'h3
// ticks that a received infrared pulse is stretched over
`define UCD_IR_STRETCH     5'h10
// index of the last data bit
`define UCD_DATA_LAST      3'h7
// last count of the divide-by-4 prescaler
`define UCD_PRESCALE_LAST  2'h3
// idle level of the standard serial line
`define UCD_LINE_IDLE      1'b1
// width of the pin synchroniser
`define UCD_SYNC_WIDTH     21

`endif

// File: verilog/ucd_pkg.sv
// types shared by the uart channel modules
package ucd_pkg;

	typedef enum logic [2:0] {
		TX_IDLE,
		TX_LOAD,
		TX_START,
		TX_DATA,
		TX_STOP
	} ucd_tx_state_type;

	typedef enum logic [1:0] {
		RX_IDLE,
		RX_START,
		RX_DATA,
		RX_STOP
	} ucd_rx_state_type;

endpackage

// File: verilog/ucd_fifo.sv
// small synchronous fifo with registered read data
`timescale 1ns/1ps
module ucd_fifo #(
	parameter int WIDTH       = 8,
	parameter int DEPTH       = 8,
	parameter int LEVEL_WIDTH = $clog2(DEPTH) + 1
) (
	input  wire logic                   ref_clk,
	input  wire logic                   reset,
	input  wire logic [WIDTH-1:0]       inData,
	input  wire logic                   inValid,
	output logic                        inReady,
	output logic [WIDTH-1:0]            outData,
	output logic                        outValid,
	input  wire logic                   outReady,
	output logic [LEVEL_WIDTH-1:0]      level
);
	// depth must be a power of two so the pointers wrap
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0]       mem [DEPTH];
	logic [AW-1:0]          wrPtr;
	logic [AW-1:0]          rdPtr;
	logic [LEVEL_WIDTH-1:0] next_level;
	logic                   push;
	logic                   pop;

	assign push = inValid & inReady;
	assign pop = outReady & outValid;
	assign next_level = level + LEVEL_WIDTH'(push) - LEVEL_WIDTH'(pop);

	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem[wrPtr] <= inData;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			wrPtr <= '0;
			rdPtr <= '0;
		end else begin
			if (push) begin
				wrPtr <= wrPtr + 1'b1;
			end
			if (pop) begin
				rdPtr <= rdPtr + 1'b1;
			end
		end
	end

	// flags from the next level so they never lag
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			level <= '0;
			inReady <= 1'b1;
			outValid <= 1'b0;
		end else begin
			level <= next_level;
			inReady <= next_level != LEVEL_WIDTH'(DEPTH);
			outValid <= next_level != '0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			outData <= '0;
		end else if (pop) begin
			outData <= mem[rdPtr];
		end
	end

endmodule // ucd_fifo

// File: verilog/ucd_channel.sv
// one uart channel: dma handshake, host data port, baud generator, serial and infrared pins
// Contract
// - terminal count pulse drops both dma requests
// - acknowledge low with address-valid starts dma
// - dma writes fill tx, reads drain rx
// - dma cycle ignores address and chip select
// - tx request until count or fill above trigger
// - tx request needs its enable bit
// - rx request until count or fifo empty
// - rx request needs its enable bit
// - ready pins carry requests when dma enabled
// - standard mode idles and resets at one
// - infrared mode idles at zero
// - infrared output always encoded, idles zero
// - receive inversion applied before infrared decoder
// - auto rts only after rts asserted
// - cts gates transmit under auto cts
// - output one becomes rs485 direction when selected
// - baud clock out is sixteen-times clock
// - bus style picks strobe scheme
// - prescaler pin latched only at reset
// - override bit supersedes latched prescaler
`timescale 1ns/1ps
`include "ucd_regs.svh"
module ucd_channel #(
	parameter int FIFO_WIDTH  = 8,
	parameter int FIFO_DEPTH  = 8,
	parameter int LEVEL_WIDTH = $clog2(FIFO_DEPTH) + 1
) (
	input  wire logic                   ref_clk,
	input  wire logic                   reset,
	input  wire logic                   dmaTerminalCount,
	input  wire logic                   dmaAddressValid,
	input  wire logic                   dmaAcknowledgeN,
	input  wire logic                   busStyleSelect,
	input  wire logic                   chipSelectN,
	input  wire logic [2:0]             registerAddressLines,
	input  wire logic                   readStrobeN,
	input  wire logic                   writeStrobeN,
	input  wire logic                   readWriteSelect,
	input  wire logic [7:0]             hostDataIn,
	output logic [7:0]                  hostDataOut,
	output logic                        hostDataValid,
	input  wire logic                   txDmaEnable,
	input  wire logic                   rxDmaEnable,
	input  wire logic                   irdaMode,
	input  wire logic                   rxInvert,
	input  wire logic                   rtsEnable,
	input  wire logic                   autoRtsEnable,
	input  wire logic                   autoCtsEnable,
	input  wire logic                   rs485Select,
	input  wire logic                   op1Software,
	input  wire logic                   op2Software,
	input  wire logic                   prescalerOverrideEnable,
	input  wire logic                   prescalerOverrideDiv4,
	input  wire logic                   prescalerSelect,
	input  wire logic [15:0]            baudDivisor,
	input  wire logic [LEVEL_WIDTH-1:0] txTriggerLevel,
	input  wire logic [LEVEL_WIDTH-1:0] rxTriggerLevel,
	output logic                        txDmaRequest,
	output logic                        rxDmaRequest,
	output logic                        txReadyStatusN,
	output logic                        rxReadyStatusN,
	output logic                        txFifoReady,
	output logic                        rxOverrun,
	output logic                        serialTxOut,
	output logic                        infraredTxOut,
	input  wire logic                   serialRxIn,
	output logic                        requestToSendN,
	input  wire logic                   clearToSendN,
	output logic                        clearToSendState,
	output logic                        generalOutputOneN,
	output logic                        generalOutputTwoN,
	output logic                        baudClockOut
);

	// ****************************************
	// pin synchroniser
	// ****************************************
	logic [`UCD_SYNC_WIDTH-1:0] syncStage1;
	logic [`UCD_SYNC_WIDTH-1:0] syncStage2;
	logic [7:0]                 sData;
	logic [2:0]                 sAddr;
	logic                       sRw;
	logic                       sCsN;
	logic                       sRdN;
	logic                       sWrN;
	logic                       sAckN;
	logic                       sAen;
	logic                       sTc;
	logic                       sRx;
	logic                       sCts;
	logic                       sPresel;

	always_ff @(posedge ref_clk) begin
		syncStage1 <= {hostDataIn, registerAddressLines, readWriteSelect, chipSelectN, readStrobeN,
			writeStrobeN, dmaAcknowledgeN, dmaAddressValid, dmaTerminalCount, serialRxIn,
			clearToSendN, prescalerSelect};
		syncStage2 <= syncStage1;
	end

	assign {sData, sAddr, sRw, sCsN, sRdN, sWrN, sAckN, sAen, sTc, sRx, sCts, sPresel} = syncStage2;

	// ****************************************
	// host strobes and dma cycle
	// ****************************************
	logic prevRdN;
	logic prevWrN;
	logic prevTc;
	logic dmaActive;
	logic selected;
	logic strobeFall;
	logic strobeIsWrite;
	logic hostWriteEvent;
	logic hostReadEvent;
	logic tcEvent;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			prevRdN <= 1'b1;
			prevWrN <= 1'b1;
			prevTc <= 1'b0;
		end else begin
			prevRdN <= sRdN;
			prevWrN <= sWrN;
			prevTc <= sTc;
		end
	end

	// the controller keeps address-valid low outside dma, so no cycle is seen then
	assign dmaActive = ~sAckN & sAen;
	assign selected = dmaActive | (~sCsN & (sAddr == `UCD_DATA_ADDR));
	// separate strobes when high, one data strobe with direction when low
	assign strobeFall = busStyleSelect ? ((prevRdN & ~sRdN) | (prevWrN & ~sWrN)) : (prevRdN & ~sRdN);
	assign strobeIsWrite = busStyleSelect ? (prevWrN & ~sWrN) : ~sRw;
	assign hostWriteEvent = strobeFall & strobeIsWrite & selected;
	assign hostReadEvent = strobeFall & ~strobeIsWrite & selected;
	assign tcEvent = sTc & ~prevTc;

	// ****************************************
	// fifos
	// ****************************************
	logic [7:0]             txOutData;
	logic                   txOutValid;
	logic                   txOutReady;
	logic [LEVEL_WIDTH-1:0] txLevel;
	logic [7:0]             rxOutData;
	logic                   rxOutValid;
	logic                   rxInReady;
	logic [LEVEL_WIDTH-1:0] rxLevel;
	logic                   rxPush;
	logic [7:0]             rxShift;
	logic                   readPending;

	ucd_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH), .LEVEL_WIDTH(LEVEL_WIDTH)) txFifo (
		.ref_clk  (ref_clk),
		.reset    (reset),
		.inData   (sData),
		.inValid  (hostWriteEvent),
		.inReady  (txFifoReady),
		.outData  (txOutData),
		.outValid (txOutValid),
		.outReady (txOutReady),
		.level    (txLevel)
	);

	ucd_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH), .LEVEL_WIDTH(LEVEL_WIDTH)) rxFifo (
		.ref_clk  (ref_clk),
		.reset    (reset),
		.inData   (rxShift),
		.inValid  (rxPush),
		.inReady  (rxInReady),
		.outData  (rxOutData),
		.outValid (rxOutValid),
		.outReady (hostReadEvent),
		.level    (rxLevel)
	);

	// read data leaves the fifo one cycle after the pop
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			readPending <= 1'b0;
			hostDataOut <= 8'h00;
			hostDataValid <= 1'b0;
		end else begin
			readPending <= hostReadEvent & rxOutValid;
			hostDataValid <= readPending;
			if (readPending) begin
				hostDataOut <= rxOutData;
			end
		end
	end

	// ****************************************
	// dma requests
	// ****************************************
	logic txBlock;
	logic rxBlock;
	logic next_txDmaRequest;
	logic next_rxDmaRequest;

	// a terminal count holds a request down until its condition clears once
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			txBlock <= 1'b0;
			rxBlock <= 1'b0;
		end else begin
			if (tcEvent) begin
				txBlock <= 1'b1;
			end else if (txLevel > txTriggerLevel) begin
				txBlock <= 1'b0;
			end
			if (tcEvent) begin
				rxBlock <= 1'b1;
			end else if (!rxOutValid) begin
				rxBlock <= 1'b0;
			end
		end
	end

	assign next_txDmaRequest = txDmaEnable & ~tcEvent & ~txBlock & (txLevel <= txTriggerLevel);
	assign next_rxDmaRequest = rxDmaEnable & ~tcEvent & ~rxBlock & rxOutValid;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			txDmaRequest <= 1'b0;
			rxDmaRequest <= 1'b0;
			txReadyStatusN <= 1'b1;
			rxReadyStatusN <= 1'b1;
		end else begin
			txDmaRequest <= next_txDmaRequest;
			rxDmaRequest <= next_rxDmaRequest;
			txReadyStatusN <= txDmaEnable ? next_txDmaRequest : ~txFifoReady;
			rxReadyStatusN <= rxDmaEnable ? next_rxDmaRequest : ~rxOutValid;
		end
	end

	// ****************************************
	// prescaler and baud generator
	// ****************************************
	logic        latchedDiv1;
	logic        divideBy4;
	logic [1:0]  prescaleCount;
	logic        prescaleTick;
	logic [15:0] divCount;
	logic [15:0] divLast;
	logic        tick16;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			latchedDiv1 <= sPresel;
		end
	end

	assign divideBy4 = prescalerOverrideEnable ? prescalerOverrideDiv4 : ~latchedDiv1;
	assign prescaleTick = divideBy4 ? (prescaleCount == `UCD_PRESCALE_LAST) : 1'b1;
	assign divLast = (baudDivisor == 16'h0000) ? 16'h0000 : baudDivisor - 16'h0001;
	assign tick16 = prescaleTick & (divCount == divLast);

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			prescaleCount <= 2'h0;
			divCount <= 16'h0000;
			baudClockOut <= 1'b0;
		end else begin
			prescaleCount <= divideBy4 ? prescaleCount + 2'h1 : 2'h0;
			if (tick16) begin
				divCount <= 16'h0000;
			end else if (prescaleTick) begin
				divCount <= divCount + 16'h0001;
			end
			baudClockOut <= divCount >= {1'b0, baudDivisor[15:1]};
		end
	end

	// ****************************************
	// transmitter and infrared encoder
	// ****************************************
	ucd_pkg::ucd_tx_state_type txState;
	logic [3:0]                txTick;
	logic [2:0]                txBit;
	logic [7:0]                txShift;
	logic                      txLine;
	logic                      txBusy;
	logic                      ctsAllows;
	logic                      irPulse;

	assign ctsAllows = ~autoCtsEnable | ~sCts;
	assign txOutReady = (txState == ucd_pkg::TX_IDLE) & ctsAllows;
	assign txBusy = txState != ucd_pkg::TX_IDLE;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			txState <= ucd_pkg::TX_IDLE;
			txTick <= 4'h0;
			txBit <= 3'h0;
			txShift <= 8'h00;
			txLine <= `UCD_LINE_IDLE;
		end else begin
			if (tick16) begin
				txTick <= txTick + 4'h1;
			end
			case (txState)
				ucd_pkg::TX_IDLE: begin
					if (txOutValid && ctsAllows) begin
						txState <= ucd_pkg::TX_LOAD;
					end
				end
				ucd_pkg::TX_LOAD: begin
					txShift <= txOutData;
					txLine <= 1'b0;
					txTick <= 4'h0;
					txState <= ucd_pkg::TX_START;
				end
				ucd_pkg::TX_START: begin
					if (tick16 && txTick == `UCD_BIT_LAST) begin
						txLine <= txShift[0];
						txShift <= {1'b0, txShift[7:1]};
						txBit <= 3'h0;
						txState <= ucd_pkg::TX_DATA;
					end
				end
				ucd_pkg::TX_DATA: begin
					if (tick16 && txTick == `UCD_BIT_LAST) begin
						txBit <= txBit + 3'h1;
						if (txBit == `UCD_DATA_LAST) begin
							txLine <= `UCD_LINE_IDLE;
							txState <= ucd_pkg::TX_STOP;
						end else begin
							txLine <= txShift[0];
							txShift <= {1'b0, txShift[7:1]};
						end
					end
				end
				ucd_pkg::TX_STOP: begin
					if (tick16 && txTick == `UCD_BIT_LAST) begin
						txState <= ucd_pkg::TX_IDLE;
					end
				end
				default: begin
					txState <= ucd_pkg::TX_IDLE;
				end
			endcase
		end
	end

	assign irPulse = txBusy & ~txLine & (txTick < `UCD_IR_PULSE_TICKS);

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			serialTxOut <= `UCD_LINE_IDLE;
			infraredTxOut <= 1'b0;
		end else begin
			serialTxOut <= irdaMode ? irPulse : txLine;
			infraredTxOut <= irPulse;
		end
	end

	// ****************************************
	// infrared decoder and receiver
	// ****************************************
	ucd_pkg::ucd_rx_state_type rxState;
	logic [3:0]                rxTick;
	logic [2:0]                rxBit;
	logic [4:0]                irStretch;
	logic                      irIn;
	logic                      rxLine;

	assign irIn = sRx ^ rxInvert;
	assign rxLine = irdaMode ? ~(irIn | (irStretch != 5'h00)) : sRx;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			irStretch <= 5'h00;
		end else if (irIn) begin
			irStretch <= `UCD_IR_STRETCH;
		end else if (tick16 && irStretch != 5'h00) begin
			irStretch <= irStretch - 5'h01;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rxState <= ucd_pkg::RX_IDLE;
			rxTick <= 4'h0;
			rxBit <= 3'h0;
			rxShift <= 8'h00;
			rxPush <= 1'b0;
			rxOverrun <= 1'b0;
		end else begin
			rxPush <= 1'b0;
			if (tick16) begin
				rxTick <= rxTick + 4'h1;
			end
			case (rxState)
				ucd_pkg::RX_IDLE: begin
					rxTick <= 4'h0;
					if (!rxLine) begin
						rxState <= ucd_pkg::RX_START;
					end
				end
				ucd_pkg::RX_START: begin
					if (tick16 && rxTick == `UCD_MID_SAMPLE) begin
						rxTick <= 4'h0;
						rxBit <= 3'h0;
						rxState <= rxLine ? ucd_pkg::RX_IDLE : ucd_pkg::RX_DATA;
					end
				end
				ucd_pkg::RX_DATA: begin
					if (tick16 && rxTick == `UCD_BIT_LAST) begin
						rxShift <= {rxLine, rxShift[7:1]};
						rxBit <= rxBit + 3'h1;
						if (rxBit == `UCD_DATA_LAST) begin
							rxState <= ucd_pkg::RX_STOP;
						end
					end
				end
				ucd_pkg::RX_STOP: begin
					if (tick16 && rxTick == `UCD_BIT_LAST) begin
						rxPush <= rxLine & rxInReady;
						rxOverrun <= rxOverrun | (rxLine & ~rxInReady);
						rxState <= ucd_pkg::RX_IDLE;
					end
				end
				default: begin
					rxState <= ucd_pkg::RX_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// modem and general purpose pins
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			requestToSendN <= 1'b1;
			clearToSendState <= 1'b1;
			generalOutputOneN <= 1'b1;
			generalOutputTwoN <= 1'b1;
		end else begin
			requestToSendN <= ~(rtsEnable & (~autoRtsEnable | (rxLevel < rxTriggerLevel)));
			clearToSendState <= sCts;
			generalOutputOneN <= rs485Select ? ~txBusy : ~op1Software;
			generalOutputTwoN <= ~op2Software;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	sequence s_dmaWrite;
		dmaActive && strobeFall && strobeIsWrite;
	endsequence

	sequence s_txQuiet;
		txState == ucd_pkg::TX_IDLE [*2];
	endsequence

	property p_tcDrops;
		@(posedge ref_clk) disable iff (reset) tcEvent |=> !txDmaRequest && !rxDmaRequest;
	endproperty
	a_tcDrops: assert property (p_tcDrops) else $error("request survived terminal count");

	property p_dmaWrite;
		@(posedge ref_clk) disable iff (reset) s_dmaWrite |-> hostWriteEvent;
	endproperty
	a_dmaWrite: assert property (p_dmaWrite) else $error("dma write not taken");

	property p_noCycle;
		@(posedge ref_clk) disable iff (reset) (sAckN || !sAen) && sCsN |-> !hostWriteEvent && !hostReadEvent;
	endproperty
	a_noCycle: assert property (p_noCycle) else $error("access without cycle");

	property p_txAbove;
		@(posedge ref_clk) disable iff (reset) txLevel > txTriggerLevel |=> !txDmaRequest;
	endproperty
	a_txAbove: assert property (p_txAbove) else $error("tx request above trigger");

	property p_txOff;
		@(posedge ref_clk) disable iff (reset) !txDmaEnable |=> !txDmaRequest;
	endproperty
	a_txOff: assert property (p_txOff) else $error("tx request while disabled");

	property p_rxEmpty;
		@(posedge ref_clk) disable iff (reset) !rxOutValid |=> !rxDmaRequest;
	endproperty
	a_rxEmpty: assert property (p_rxEmpty) else $error("rx request while empty");

	property p_rxOff;
		@(posedge ref_clk) disable iff (reset) !rxDmaEnable |=> !rxDmaRequest;
	endproperty
	a_rxOff: assert property (p_rxOff) else $error("rx request while disabled");

	property p_pinCarries;
		@(posedge ref_clk) disable iff (reset) $past(txDmaEnable) && !$past(reset) |-> txReadyStatusN == txDmaRequest;
	endproperty
	a_pinCarries: assert property (p_pinCarries) else $error("ready pin not carrying request");

	property p_stdIdle;
		@(posedge ref_clk) disable iff (reset) s_txQuiet ##0 !irdaMode |=> serialTxOut;
	endproperty
	a_stdIdle: assert property (p_stdIdle) else $error("standard line not idle high");

	property p_irIdle;
		@(posedge ref_clk) disable iff (reset)
			s_txQuiet |=> !infraredTxOut && (!irdaMode || !$past(irdaMode) || !serialTxOut);
	endproperty
	a_irIdle: assert property (p_irIdle) else $error("infrared line not idle low");

	property p_rtsOff;
		@(posedge ref_clk) disable iff (reset) !rtsEnable |=> requestToSendN;
	endproperty
	a_rtsOff: assert property (p_rtsOff) else $error("rts asserted without enable");

	property p_ctsHold;
		@(posedge ref_clk) disable iff (reset)
			autoCtsEnable && sCts && txState == ucd_pkg::TX_IDLE |=> txState == ucd_pkg::TX_IDLE;
	endproperty
	a_ctsHold: assert property (p_ctsHold) else $error("sent against clear-to-send");

	property p_presHeld;
		@(posedge ref_clk) !reset && !$past(reset) |-> $stable(latchedDiv1);
	endproperty
	a_presHeld: assert property (p_presHeld) else $error("prescaler changed after reset");

endmodule // ucd_channel

// File: tb/ucd_far_end.sv
// remote modem model: echoes the serial line and drives clear to send
`timescale 1ns/1ps
module ucd_far_end (
	input  wire logic ref_clk,
	input  wire logic txLine,
	input  wire logic holdOff,
	output logic      rxLine,
	output logic      clearToSendN
);
	// ****
	// echo with one clock of wire delay, idle level follows the line
	// ****
	always_ff @(posedge ref_clk) begin
		rxLine <= txLine;
	end
	assign clearToSendN = holdOff;
endmodule // ucd_far_end

// File: tb/tb.sv
// self-checking bench for the uart channel: dma handshake, serial pins, baud clock
`timescale 1ns/1ps
`define CHK(a, e) cmp(16'(a), 16'(e))
module tb;
	logic        ref_clk, reset, dmaTerminalCount, dmaAddressValid, dmaAcknowledgeN, busStyleSelect, chipSelectN;
	logic        readStrobeN, writeStrobeN, readWriteSelect, txDmaEnable, rxDmaEnable, irdaMode, rxInvert;
	logic        rtsEnable, autoRtsEnable, autoCtsEnable, rs485Select, op1Software, op2Software, holdOff;
	logic        prescalerOverrideEnable, prescalerOverrideDiv4, prescalerSelect, serialRxIn, clearToSendN;
	logic        hostDataValid, txDmaRequest, rxDmaRequest, txReadyStatusN, rxReadyStatusN, txFifoReady;
	logic        rxOverrun, serialTxOut, infraredTxOut, requestToSendN, clearToSendState, generalOutputOneN;
	logic        generalOutputTwoN, baudClockOut;
	logic [2:0]  registerAddressLines;
	logic [7:0]  hostDataIn, hostDataOut, got;
	logic [15:0] baudDivisor;
	logic [3:0]  txTriggerLevel, rxTriggerLevel;
	logic [7:0]  bytes [3] = '{8'hA5, 8'h3C, 8'h81};
	int          error_cnt, check_count, cycles;

	ucd_channel uut (.ref_clk, .reset, .dmaTerminalCount, .dmaAddressValid, .dmaAcknowledgeN, .busStyleSelect,
		.chipSelectN, .registerAddressLines, .readStrobeN, .writeStrobeN, .readWriteSelect, .hostDataIn,
		.hostDataOut, .hostDataValid, .txDmaEnable, .rxDmaEnable, .irdaMode, .rxInvert, .rtsEnable,
		.autoRtsEnable, .autoCtsEnable, .rs485Select, .op1Software, .op2Software, .prescalerOverrideEnable,
		.prescalerOverrideDiv4, .prescalerSelect, .baudDivisor, .txTriggerLevel, .rxTriggerLevel, .txDmaRequest,
		.rxDmaRequest, .txReadyStatusN, .rxReadyStatusN, .txFifoReady, .rxOverrun, .serialTxOut, .infraredTxOut,
		.serialRxIn, .requestToSendN, .clearToSendN, .clearToSendState, .generalOutputOneN, .generalOutputTwoN,
		.baudClockOut);
	ucd_far_end modem (.ref_clk, .txLine(serialTxOut), .holdOff, .rxLine(serialRxIn), .clearToSendN);

	// ****
	// clock, timeout, compare and close
	// ****
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			test_done();
		end
	end
	task automatic cmp(input logic [15:0] a, input logic [15:0] e);
		check_count++;
		if (a !== e) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, a, e);
		end
	endtask
	task automatic test_done();
		$display("checks=%0d errors=%0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	// one dma strobe, address and chip select pointed away from the data port
	task automatic dma_access(input logic wr, input logic [7:0] d);
		@(negedge ref_clk);
		got = 8'h00;
		dmaAddressValid = 1'b1;
		dmaAcknowledgeN = 1'b0;
		chipSelectN = 1'b1;
		registerAddressLines = 3'h5;
		hostDataIn = d;
		if (wr) writeStrobeN = 1'b0;
		else readStrobeN = 1'b0;
		for (int i = 0; i < 8; i++) begin
			@(negedge ref_clk);
			if (hostDataValid === 1'b1) got = hostDataOut;
		end
		writeStrobeN = 1'b1;
		readStrobeN = 1'b1;
		tick(4);
		dmaAddressValid = 1'b0;
		dmaAcknowledgeN = 1'b1;
	endtask
	task automatic baud_rises(input int exp);
		int n;
		logic prev;
		n = 0;
		prev = baudClockOut;
		repeat (32) begin
			@(negedge ref_clk);
			if (baudClockOut === 1'b1 && prev === 1'b0) n++;
			prev = baudClockOut;
		end
		`CHK(n, exp);
	endtask

	// ****
	// scenarios
	// ****
	task automatic t_pins();
		op1Software = 1'b1;
		rtsEnable = 1'b1;
		autoRtsEnable = 1'b1;
		tick(4);
		`CHK(generalOutputOneN, 1'b0);
		`CHK(generalOutputTwoN, 1'b1);
		`CHK(requestToSendN, 1'b0);
		`CHK(txDmaRequest, 1'b0);
		`CHK(txReadyStatusN, 1'b0);
		rtsEnable = 1'b0;
		tick(4);
		`CHK(requestToSendN, 1'b1);
	endtask
	task automatic t_dma();
		autoCtsEnable = 1'b1;
		holdOff = 1'b1;
		txDmaEnable = 1'b1;
		rxDmaEnable = 1'b1;
		tick(4);
		`CHK(txDmaRequest, 1'b1);
		`CHK(txReadyStatusN, 1'b1);
		`CHK(rxDmaRequest, 1'b0);
		dmaTerminalCount = 1'b1;
		tick(1);
		dmaTerminalCount = 1'b0;
		tick(3);
		`CHK(txDmaRequest, 1'b0);
		foreach (bytes[k]) dma_access(1'b1, bytes[k]);
		tick(100);
		`CHK(serialTxOut, 1'b1);
		`CHK(txDmaRequest, 1'b0);
		rs485Select = 1'b1;
		holdOff = 1'b0;
		tick(60);
		`CHK(generalOutputOneN, 1'b0);
		foreach (bytes[k]) begin
			for (int i = 0; i < 2000 && rxDmaRequest !== 1'b1; i++) @(negedge ref_clk);
			`CHK(rxDmaRequest, 1'b1);
			dma_access(1'b0, 8'h00);
			`CHK(got, bytes[k]);
		end
		tick(4);
		`CHK(rxDmaRequest, 1'b0);
		`CHK(rxReadyStatusN, 1'b0);
		`CHK(txDmaRequest, 1'b1);
	endtask
	task automatic t_baud();
		baud_rises(16);
		prescalerOverrideEnable = 1'b1;
		prescalerOverrideDiv4 = 1'b1;
		tick(4);
		baud_rises(4);
		prescalerOverrideEnable = 1'b0;
		prescalerSelect = 1'b0;
		tick(4);
		baud_rises(16);
		reset = 1'b1;
		tick(4);
		reset = 1'b0;
		tick(4);
		baud_rises(4);
	endtask

	initial begin
		{dmaTerminalCount, dmaAddressValid, readWriteSelect, txDmaEnable, rxDmaEnable, irdaMode} = '0;
		{rxInvert, rtsEnable, autoRtsEnable, autoCtsEnable, rs485Select, op1Software, op2Software} = '0;
		{prescalerOverrideEnable, prescalerOverrideDiv4, holdOff} = '0;
		{reset, dmaAcknowledgeN, busStyleSelect, chipSelectN, readStrobeN, writeStrobeN, prescalerSelect} = '1;
		registerAddressLines = 3'h0;
		hostDataIn = 8'h00;
		baudDivisor = 16'h0002;
		txTriggerLevel = 4'h2;
		rxTriggerLevel = 4'h4;
		tick(3);
		`CHK(serialTxOut, 1'b1);
		`CHK(infraredTxOut, 1'b0);
		reset = 1'b0;
		t_pins();
		t_dma();
		irdaMode = 1'b1;
		tick(100);
		`CHK(serialTxOut, 1'b0);
		`CHK(infraredTxOut, 1'b0);
		`CHK(rxDmaRequest, 1'b0);
		t_baud();
		test_done();
	end
endmodule // tb
